// ---- src/lscm_alu.sv ----
/*
  Logic, shift, compare and move execution datapath with N, Z, C, V flags.
  Assumes the decoder delivers one operation per issue pulse with operands
  already read from the register file, and that it keeps operand limits.
*/
// Operation
// - AND, EOR, ORR combine operands bitwise
// - Bit clear Bitwise_conjunction first with inverted second
// - Logic ops set N and Z
// - Logic ops keep C and V
// - Register shift count uses low byte
// - Shifts set N and Z from result
// - Carry gets last bit out, zero keeps
// - Shifts never modify V
// - Flag-setting move equals shift left zero
// - Compare subtracts, sets flags, no write
// - Compare-add adds, sets flags, no write
// - Compares update all four flags
// - Plain move copies source unchanged
// - Flag move sets N,Z; plain keeps flags
// - Inverted move writes complement
// - Move to counter clears bit zero, branches
`timescale 1ns/1ps
`default_nettype none

module lscm_alu
  import lscm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Issue from decoder
  input wire logic issue,
  input wire lscm_pkg::lscm_op_t op,
  input wire logic [3:0] dest_idx,
  input wire logic [31:0] first_operand_reg,
  input wire logic [31:0] second_operand_reg,
  input wire logic [31:0] shift_amount_reg,
  input wire logic use_imm,
  input wire logic [7:0] imm,
  // Result to register file
  output logic done,
  output logic wr_en,
  output logic [3:0] wr_idx,
  output logic [31:0] wr_data,
  // Branch through program counter
  output logic branch,
  output logic [31:0] branch_target,
  // Condition flags
  output logic [3:0] flags
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic is_logic_op(input lscm_op_t o);
    is_logic_op = (o == LSCM_BITWISE_CONJUNCTION) || (o == LSCM_BITWISE_EXCLUSIVE_OR) ||
                  (o == LSCM_BITWISE_INCLUSIVE_OR) || (o == LSCM_BIT_CLEAR_OP);
  endfunction : is_logic_op

  function automatic logic is_shift_op(input lscm_op_t o);
    is_shift_op = (o == LSCM_ARITH_RIGHT_SHIFT) || (o == LSCM_LOGICAL_LEFT_SHIFT) ||
                  (o == LSCM_LOGICAL_RIGHT_SHIFT) || (o == LSCM_ROTATE_RIGHT_OP) ||
                  (o == LSCM_FLAG_SETTING_COPY);
  endfunction : is_shift_op

  lscm_state_t state_r;
  lscm_state_t state_nxt;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic done_r;
  logic wr_en_r;
  logic wr_en_nxt;
  logic [3:0] wr_idx_r;
  logic [31:0] wr_data_r;
  logic [31:0] wr_data_nxt;
  logic branch_r;
  logic branch_nxt;
  logic [31:0] branch_target_r;

  wire logic logic_op = is_logic_op(op);
  wire logic shift_op = is_shift_op(op);
  wire logic compare_op = (op == LSCM_COMPARE_SUBTRACT) || (op == LSCM_COMPARE_ADD);
  wire logic to_pc = (op == LSCM_REGISTER_COPY) && (dest_idx == `LSCM_PC_IDX);

  // ----------------------------------------------------------------
  // Bitwise logic
  // ----------------------------------------------------------------
  logic [31:0] logic_res;
  always_comb
  begin
    case (op)
      LSCM_BITWISE_CONJUNCTION:
      begin
        logic_res = first_operand_reg & second_operand_reg;
      end
      LSCM_BITWISE_EXCLUSIVE_OR:
      begin
        logic_res = first_operand_reg ^ second_operand_reg;
      end
      LSCM_BITWISE_INCLUSIVE_OR:
      begin
        logic_res = first_operand_reg | second_operand_reg;
      end
      LSCM_BIT_CLEAR_OP:
      begin
        logic_res = first_operand_reg & ~second_operand_reg;
      end
      default:
      begin
        logic_res = 32'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Shifts and rotate
  // ----------------------------------------------------------------
  // Rotate ignores use_imm since no immediate form exists for it
  wire logic amt_from_imm = use_imm && (op != LSCM_ROTATE_RIGHT_OP);
  // Flag-setting copy runs as a left shift by zero
  wire logic [7:0] shift_amt = (op == LSCM_FLAG_SETTING_COPY) ? 8'h00 :
                               amt_from_imm ? imm : shift_amount_reg[7:0];
  lscm_shift_t shift_kind;
  always_comb
  begin
    case (op)
      LSCM_ARITH_RIGHT_SHIFT:
      begin
        shift_kind = LSCM_SH_ASR;
      end
      LSCM_LOGICAL_RIGHT_SHIFT:
      begin
        shift_kind = LSCM_SH_LSR;
      end
      LSCM_ROTATE_RIGHT_OP:
      begin
        shift_kind = LSCM_SH_ROR;
      end
      default:
      begin
        shift_kind = LSCM_SH_LSL;
      end
    endcase
  end

  logic [31:0] shift_res;
  logic shift_carry;
  lscm_shifter u_shifter (
    .value(second_operand_reg),
    .amount(shift_amt),
    .kind(shift_kind),
    .carry_in(flags_r[`LSCM_FLAG_C]),
    .result(shift_res),
    .carry_out(shift_carry)
  );

  // ----------------------------------------------------------------
  // Compares
  // ----------------------------------------------------------------
  wire logic [31:0] cmp_b = use_imm ? {24'h0, imm} : second_operand_reg;
  wire logic [32:0] sub_ext = {1'b0, first_operand_reg} + {1'b0, ~cmp_b} + 33'h1;
  wire logic [32:0] add_ext = {1'b0, first_operand_reg} + {1'b0, second_operand_reg};
  wire logic is_sub = (op == LSCM_COMPARE_SUBTRACT);
  wire logic [31:0] cmp_res = is_sub ? sub_ext[31:0] : add_ext[31:0];
  wire logic cmp_c = is_sub ? sub_ext[32] : add_ext[32];
  // Overflow when the operand signs make the true result unrepresentable
  wire logic sub_v = (first_operand_reg[31] != cmp_b[31]) &&
                     (cmp_res[31] != first_operand_reg[31]);
  wire logic add_v = (first_operand_reg[31] == second_operand_reg[31]) &&
                     (cmp_res[31] != first_operand_reg[31]);
  wire logic cmp_v = is_sub ? sub_v : add_v;

  // ----------------------------------------------------------------
  // Result and flag selection
  // ----------------------------------------------------------------
  always_comb
  begin
    flags_nxt = flags_r;
    wr_en_nxt = 1'b0;
    wr_data_nxt = 32'h0;
    branch_nxt = 1'b0;
    if (logic_op)
    begin
      wr_en_nxt = 1'b1;
      wr_data_nxt = logic_res;
      flags_nxt[`LSCM_FLAG_N] = logic_res[31];
      flags_nxt[`LSCM_FLAG_Z] = (logic_res == 32'h0);
    end
    else if (shift_op)
    begin
      wr_en_nxt = 1'b1;
      wr_data_nxt = shift_res;
      flags_nxt[`LSCM_FLAG_N] = shift_res[31];
      flags_nxt[`LSCM_FLAG_Z] = (shift_res == 32'h0);
      flags_nxt[`LSCM_FLAG_C] = shift_carry;
    end
    else if (compare_op)
    begin
      flags_nxt[`LSCM_FLAG_N] = cmp_res[31];
      flags_nxt[`LSCM_FLAG_Z] = (cmp_res == 32'h0);
      flags_nxt[`LSCM_FLAG_C] = cmp_c;
      flags_nxt[`LSCM_FLAG_V] = cmp_v;
    end
    else if (op == LSCM_REGISTER_COPY)
    begin
      // No flag change on plain copy
      wr_en_nxt = !to_pc;
      wr_data_nxt = second_operand_reg;
      branch_nxt = to_pc;
    end
    else if (op == LSCM_INVERTED_COPY)
    begin
      wr_en_nxt = 1'b1;
      wr_data_nxt = ~second_operand_reg;
      flags_nxt[`LSCM_FLAG_N] = ~second_operand_reg[31];
      flags_nxt[`LSCM_FLAG_Z] = (second_operand_reg == 32'hFFFFFFFF);
    end
    else if (op == LSCM_IMMEDIATE_COPY)
    begin
      wr_en_nxt = 1'b1;
      wr_data_nxt = {24'h0, imm};
      flags_nxt[`LSCM_FLAG_N] = 1'b0;
      flags_nxt[`LSCM_FLAG_Z] = (imm == 8'h00);
    end
  end

  always_comb
  begin
    case (state_r)
      LSCM_ST_IDLE:
      begin
        state_nxt = issue ? LSCM_ST_DONE : LSCM_ST_IDLE;
      end
      LSCM_ST_DONE:
      begin
        state_nxt = issue ? LSCM_ST_DONE : LSCM_ST_IDLE;
      end
      default:
      begin
        state_nxt = LSCM_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // One issue per cycle is taken; each answers one cycle later
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r <= LSCM_ST_IDLE;
      flags_r <= `LSCM_FLAGS_RST;
      done_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_idx_r <= 4'h0;
      wr_data_r <= 32'h0;
      branch_r <= 1'b0;
      branch_target_r <= 32'h0;
    end
    else
    begin
      state_r <= state_nxt;
      done_r <= issue;
      wr_en_r <= issue & wr_en_nxt;
      branch_r <= issue & branch_nxt;
      if (issue)
      begin
        flags_r <= flags_nxt;
        wr_idx_r <= dest_idx;
        wr_data_r <= wr_data_nxt;
        // Captured on every issue so it stands until the next one
        branch_target_r <= {second_operand_reg[31:1], 1'b0};
      end
    end
  end

  assign done = done_r;
  assign wr_en = wr_en_r;
  assign wr_idx = wr_idx_r;
  assign wr_data = wr_data_r;
  assign branch = branch_r;
  assign branch_target = branch_target_r;
  assign flags = flags_r;

endmodule : lscm_alu

`default_nettype wire

// ---- src/lscm_map.svh ----
/*
  Constants of the logic, shift, compare and move datapath: opcode codes,
  field widths, register index limits and flag bit positions.
  Assumes inclusion by bare name from the package and the bench files.
*/
`ifndef LSCM_MAP_SVH
`define LSCM_MAP_SVH

`define LSCM_OP_W 4
`define LSCM_OP_AND 4'h0
`define LSCM_OP_EOR 4'h1
`define LSCM_OP_ORR 4'h2
`define LSCM_OP_BIC 4'h3
`define LSCM_OP_ASR 4'h4
`define LSCM_OP_LSL 4'h5
`define LSCM_OP_LSR 4'h6
`define LSCM_OP_ROR 4'h7
`define LSCM_OP_CMP 4'h8
`define LSCM_OP_CMN 4'h9
`define LSCM_OP_MOV 4'hA
`define LSCM_OP_FLAG_SETTING_COPY 4'hB
`define LSCM_OP_MVN 4'hC
`define LSCM_OP_MOVI 4'hD
`define LSCM_OP_NOP 4'hF

`define LSCM_PC_IDX 4'hF
`define LSCM_AMT_W 8
`define LSCM_IMM_W 8
`define LSCM_FLAG_N 3
`define LSCM_FLAG_Z 2
`define LSCM_FLAG_C 1
`define LSCM_FLAG_V 0
`define LSCM_FLAGS_RST 4'h0

`endif

// ---- src/lscm_pkg.sv ----
/*
  Types of the logic, shift, compare and move datapath.
  Assumes the constants header lscm_map.svh on the include path.
*/
`include "lscm_map.svh"

package lscm_pkg;

  typedef enum logic [`LSCM_OP_W-1:0] {
    LSCM_BITWISE_CONJUNCTION = `LSCM_OP_AND,
    LSCM_BITWISE_EXCLUSIVE_OR = `LSCM_OP_EOR,
    LSCM_BITWISE_INCLUSIVE_OR = `LSCM_OP_ORR,
    LSCM_BIT_CLEAR_OP = `LSCM_OP_BIC,
    LSCM_ARITH_RIGHT_SHIFT = `LSCM_OP_ASR,
    LSCM_LOGICAL_LEFT_SHIFT = `LSCM_OP_LSL,
    LSCM_LOGICAL_RIGHT_SHIFT = `LSCM_OP_LSR,
    LSCM_ROTATE_RIGHT_OP = `LSCM_OP_ROR,
    LSCM_COMPARE_SUBTRACT = `LSCM_OP_CMP,
    LSCM_COMPARE_ADD = `LSCM_OP_CMN,
    LSCM_REGISTER_COPY = `LSCM_OP_MOV,
    LSCM_FLAG_SETTING_COPY = `LSCM_OP_FLAG_SETTING_COPY,
    LSCM_INVERTED_COPY = `LSCM_OP_MVN,
    LSCM_IMMEDIATE_COPY = `LSCM_OP_MOVI,
    LSCM_NO_OP = `LSCM_OP_NOP
  } lscm_op_t;

  typedef enum logic [1:0] {
    LSCM_SH_LSL = 2'h0,
    LSCM_SH_LSR = 2'h1,
    LSCM_SH_ASR = 2'h2,
    LSCM_SH_ROR = 2'h3
  } lscm_shift_t;

  typedef enum logic [1:0] {
    LSCM_ST_IDLE = 2'h1,
    LSCM_ST_DONE = 2'h2
  } lscm_state_t;

endpackage : lscm_pkg

// ---- src/lscm_shifter.sv ----
/*
  Combinational 32-bit shifter with carry-out for the datapath.
  Assumes the caller holds the carry-in and passes the full 8-bit count.
*/
`timescale 1ns/1ps
`default_nettype none

module lscm_shifter
  import lscm_pkg::*;
(
  // Operand
  input wire logic [31:0] value,
  input wire logic [7:0] amount,
  input wire lscm_pkg::lscm_shift_t kind,
  input wire logic carry_in,
  // Result
  output logic [31:0] result,
  output logic carry_out
);

  // ----------------------------------------------------------------
  // Shift by the 8-bit count; counts of 32 and above saturate, except rotate, which rotates by count bits 4:0 and keeps carry only at count 0
  // ----------------------------------------------------------------
  wire logic big = (amount >= 8'h20);
  wire logic [4:0] sh = amount[4:0];
  wire logic [4:0] rot = amount[4:0];
  wire logic zero_amt = (amount == 8'h00);
  wire logic [63:0] ror_dbl = {value, value} >> rot;
  wire logic [32:0] lsl_ext = {1'b0, value} << sh;
  wire logic [32:0] lsr_ext = {value, 1'b0} >> sh;
  wire logic [32:0] asr_ext = 33'($signed({value, 1'b0}) >>> sh);

  always_comb
  begin
    result = value;
    carry_out = carry_in;
    if (!zero_amt)
    begin
      case (kind)
        LSCM_SH_LSL:
        begin
          result = big ? 32'h0 : lsl_ext[31:0];
          carry_out = big ? ((amount == 8'h20) & value[0]) : lsl_ext[32];
        end
        LSCM_SH_LSR:
        begin
          result = big ? 32'h0 : lsr_ext[32:1];
          carry_out = big ? ((amount == 8'h20) & value[31]) : lsr_ext[0];
        end
        LSCM_SH_ASR:
        begin
          result = big ? {32{value[31]}} : asr_ext[32:1];
          carry_out = big ? value[31] : asr_ext[0];
        end
        LSCM_SH_ROR:
        begin
          result = ror_dbl[31:0];
          carry_out = ror_dbl[31];
        end
        default:
        begin
          result = value;
          carry_out = carry_in;
        end
      endcase
    end
  end

endmodule : lscm_shifter

`default_nettype wire

// ---- tb/lscm_alu_properties.sv ----
/*
  Checker for lscm_alu: result and flag relations one cycle after issue.
  Assumes it is bound to every lscm_alu instance.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lscm_map.svh"

module lscm_alu_props
  import lscm_pkg::*;
(
  // Clock, reset, issue
  input wire logic clock,
  input wire logic rst,
  input wire logic issue,
  input wire lscm_pkg::lscm_op_t op,
  input wire logic [3:0] dest_idx,
  // Operands
  input wire logic [31:0] first_operand_reg,
  input wire logic [31:0] second_operand_reg,
  input wire logic [31:0] shift_amount_reg,
  input wire logic use_imm,
  input wire logic [7:0] imm,
  // Results
  input wire logic done,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic branch,
  input wire logic [31:0] branch_target,
  input wire logic [3:0] flags
);
  wire logic [31:0] a = first_operand_reg;
  wire logic [31:0] b = second_operand_reg;
  wire logic nz_ok = flags[3] == wr_data[31] && flags[2] == (wr_data == 32'h0);
  wire logic sh = op[3:2] == 2'h1;
  wire logic cnt0 = (use_imm && op != `LSCM_OP_ROR ? imm : shift_amount_reg[7:0]) == 8'h0;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_take(logic [3:0] c);
    issue && op == c;
  endsequence
  sequence s_cv_kept;
    flags[1:0] == $past(flags[1:0]);
  endsequence

  AST_AND: assert property (s_take(`LSCM_OP_AND) |=> wr_data == ($past(a) & $past(b)))
    else $error("conjunction result wrong");
  AST_LOGIC_FLAGS: assert property (issue && op[3:2] == 2'h0 |=> nz_ok ##0 s_cv_kept)
    else $error("logic flags wrong");
  AST_SHIFT_FLAGS: assert property (issue && sh |=> nz_ok && flags[0] == $past(flags[0]))
    else $error("shift flags wrong");
  AST_SHIFT_ZERO: assert property (issue && sh && cnt0 |=> s_cv_kept ##0 wr_data == $past(b))
    else $error("zero count shift wrong");
  AST_FLAG_SETTING_COPY: assert property (s_take(`LSCM_OP_FLAG_SETTING_COPY) |=> wr_data == $past(b) && nz_ok ##0 s_cv_kept)
    else $error("flag move wrong");
  AST_CMP_NOWR: assert property (issue && op inside {`LSCM_OP_CMP, `LSCM_OP_CMN} |=> done && !wr_en)
    else $error("compare wrote a register");
  AST_CMP_ZC: assert property (s_take(`LSCM_OP_CMP) && !use_imm |=>
    flags[2] == ($past(a) == $past(b)) && flags[1] == ($past(a) >= $past(b)))
    else $error("compare flags wrong");
  AST_MOV: assert property (s_take(`LSCM_OP_MOV) |=>
    flags == $past(flags) && branch == ($past(dest_idx) == 4'hF) && (branch || wr_data == $past(b)))
    else $error("plain move wrong");
  AST_MVN: assert property (s_take(`LSCM_OP_MVN) |=> wr_data == ~$past(b))
    else $error("inverted move wrong");
endmodule : lscm_alu_props

bind lscm_alu lscm_alu_props u_props (.clock, .rst, .issue, .op, .dest_idx, .first_operand_reg,
  .second_operand_reg, .shift_amount_reg, .use_imm, .imm, .done, .wr_en, .wr_idx, .wr_data,
  .branch, .branch_target, .flags);
`default_nettype wire

// ---- tb/lscm_dec_model.sv ----
/*
  Decoder model: turns bench requests into legal issue fields.
  Assumes operand values go straight from the bench to the datapath.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lscm_map.svh"

module lscm_dec_model
  import lscm_pkg::*;
(
  // Request
  input wire logic req_issue,
  input wire logic [3:0] req_op,
  input wire logic [3:0] req_dest,
  input wire logic req_ui,
  input wire logic [7:0] req_imm,
  // Issue
  output logic issue,
  output lscm_pkg::lscm_op_t op,
  output logic [3:0] dest_idx,
  output logic use_imm,
  output logic [7:0] imm
);
  wire logic sh = req_op inside {`LSCM_OP_ASR, `LSCM_OP_LSL, `LSCM_OP_LSR};
  wire logic rsh = req_op != `LSCM_OP_LSL;
  assign issue = req_issue;
  assign op = lscm_op_t'(req_op);
  // Only a move reaches high registers; first operand doubles as destination
  assign dest_idx = req_op == `LSCM_OP_MOV ? req_dest : {1'b0, req_dest[2:0]};
  // Rotate has no immediate form
  assign use_imm = req_ui && (sh || req_op == `LSCM_OP_CMP);
  // Right shifts 1 to 32, left 0 to 31, other immediates 0 to 255
  assign imm = !use_imm || !sh ? req_imm : {3'h0, req_imm[4:0]} + {7'h0, rsh};
endmodule : lscm_dec_model
`default_nettype wire

// ---- tb/lscm_alu_tb.sv ----
/*
  Bench for lscm_alu: directed corners, then seeded random back-to-back ops.
  Assumes the package, the checker and the decoder model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lscm_map.svh"

module lscm_alu_tb;
  import lscm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic iss = 1'b0;
  logic ui = 1'b0;
  logic [3:0] rop = 4'hF;
  logic [3:0] rd = 4'h0;
  logic [3:0] ei = 4'h0;
  logic [3:0] ef = 4'h0;
  logic [7:0] rim = 8'h0;
  logic [31:0] a = 32'h0;
  logic [31:0] b = 32'h0;
  logic [31:0] s = 32'h0;
  logic [31:0] x = 32'h0;
  logic [31:0] r = 32'h0;
  logic [31:0] ed = 32'h0;
  logic [31:0] seed = 32'hD574AACA;
  logic [2:0] ek = 3'h0;
  int failures = 0;
  int checked = 0;
  wire logic d_iss, d_ui, done, wr_en, branch;
  wire lscm_op_t d_op;
  wire logic [3:0] d_rd, wr_idx, flags;
  wire logic [7:0] d_im;
  wire logic [31:0] wr_data, tgt;

  initial forever #5 clock = ~clock;

  lscm_dec_model u_dec (.req_issue(iss), .req_op(rop), .req_dest(rd), .req_ui(ui),
    .req_imm(rim), .issue(d_iss), .op(d_op), .dest_idx(d_rd), .use_imm(d_ui), .imm(d_im));
  lscm_alu u_dut (.clock(clock), .rst(rst), .issue(d_iss), .op(d_op), .dest_idx(d_rd),
    .first_operand_reg(a), .second_operand_reg(b), .shift_amount_reg(s), .use_imm(d_ui),
    .imm(d_im), .done(done), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .branch(branch), .branch_target(tgt), .flags(flags));

  // ----------------------------------------
  // Reference and comparison
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Works from the issued fields; flags are tracked here, never read back
  task automatic calc;
    logic [63:0] t;
    logic [32:0] u;
    logic [31:0] y;
    logic [7:0] n;
    logic c;
    logic v;
    logic br;
    n = d_ui ? d_im : s[7:0];
    y = d_ui ? {24'h0, d_im} : b;
    {r, c, v, t, u} = {b, ef[1:0], 64'h0, 33'h0};
    case (d_op)
      `LSCM_OP_AND: r = a & b;
      `LSCM_OP_EOR: r = a ^ b;
      `LSCM_OP_ORR: r = a | b;
      `LSCM_OP_BIC: r = a & ~b;
      `LSCM_OP_LSL: t = {32'h0, b} << n;
      `LSCM_OP_LSR: t = {b, 32'h0} >> n;
      `LSCM_OP_ASR: t = $signed({b, 32'h0}) >>> n;
      `LSCM_OP_ROR: r = (b >> n[4:0]) | (b << (6'd32 - n[4:0]));
      `LSCM_OP_CMP: u = {1'b0, a} + {1'b0, ~y} + 33'h1;
      `LSCM_OP_CMN: u = {1'b0, a} + {1'b0, b};
      `LSCM_OP_MVN: r = ~b;
      `LSCM_OP_MOVI: r = {24'h0, d_im};
      default: ;
    endcase
    if (d_op == `LSCM_OP_LSL) {c, r} = t[32:0];
    if (d_op inside {`LSCM_OP_LSR, `LSCM_OP_ASR}) {r, c} = t[63:31];
    if (d_op == `LSCM_OP_ROR) c = r[31];
    if (d_op inside {`LSCM_OP_CMP, `LSCM_OP_CMN}) {c, r} = u;
    if (d_op == `LSCM_OP_CMP) v = a[31] != y[31] && r[31] != a[31];
    if (d_op == `LSCM_OP_CMN) v = a[31] == b[31] && r[31] != a[31];
    if (d_op[3:2] == 2'h1 && n == 8'h0) c = ef[1];
    if (d_op != `LSCM_OP_MOV && d_op != `LSCM_OP_NOP) ef = {r[31], r == 32'h0, c, v};
    br = d_op == `LSCM_OP_MOV && d_rd == 4'hF;
    ek = {1'b1, !(d_op inside {`LSCM_OP_CMP, `LSCM_OP_CMN, `LSCM_OP_NOP}) && !br, br};
    ed = br ? {b[31:1], 1'b0} : r;
    ei = d_rd;
  endtask : calc

  task automatic check;
    if (ek[2])
    begin
      chk("done", 32'h1, done);
      chk("wr_en", ek[1], wr_en);
      chk("branch", ek[0], branch);
      if (ek[1]) chk("wr_data", ed, wr_data);
      if (ek[1]) chk("wr_idx", ei, wr_idx);
      if (ek[0]) chk("target", ed, tgt);
      chk("flags", ef, flags);
    end
  endtask : check

  task automatic op_do(input logic [3:0] o, input logic [31:0] va, input logic [31:0] vb,
    input logic [31:0] vs, input logic u, input logic [7:0] im, input logic [3:0] d);
    @(posedge clock);
    iss <= 1'b1;
    {rop, a, b, s, ui, rim, rd} <= {o, va, vb, vs, u, im, d};
    @(negedge clock);
    check;
    calc;
  endtask : op_do

  task automatic results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    op_do(`LSCM_OP_CMP, 32'h5, 32'h5, 32'h0, 1'b0, 8'h0, 4'h0);
    op_do(`LSCM_OP_LSL, 32'h0, 32'h80000001, 32'hFFFFFF00, 1'b0, 8'h0, 4'h1);
    op_do(`LSCM_OP_LSL, 32'h0, 32'h80000001, 32'h101, 1'b0, 8'h0, 4'h2);
    op_do(`LSCM_OP_CMP, 32'h80000000, 32'h0, 32'h0, 1'b1, 8'h1, 4'h0);
    op_do(`LSCM_OP_LSR, 32'h0, 32'h80000001, 32'h0, 1'b1, 8'h1F, 4'h3);
    op_do(`LSCM_OP_ASR, 32'h0, 32'h80000000, 32'hC8, 1'b0, 8'h0, 4'h4);
    op_do(`LSCM_OP_ROR, 32'h0, 32'hF, 32'h24, 1'b1, 8'h0, 4'h5);
    op_do(`LSCM_OP_CMN, 32'hFFFFFFFF, 32'h1, 32'h0, 1'b0, 8'h0, 4'h0);
    op_do(`LSCM_OP_MOV, 32'h0, 32'h1235, 32'h0, 1'b0, 8'h0, 4'hF);
    op_do(`LSCM_OP_BIC, 32'hFF, 32'hF, 32'h0, 1'b0, 8'h0, 4'h6);
    repeat (3000)
    begin
      r = rnd();
      x = rnd();
      op_do(r[3:0] == 4'hE ? 4'hF : r[3:0], x, r[4] ? x : rnd(), rnd() & 32'hFFFFFFBF, r[5],
        r[15:8], r[19:16]);
    end
    @(posedge clock);
    iss <= 1'b0;
    @(negedge clock);
    check;
    @(negedge clock);
    chk("done_idle", 32'h0, done);
    chk("wr_en_idle", 32'h0, wr_en);
    chk("branch_idle", 32'h0, branch);
    results;
  end

  // A hang counts as a mismatch
  initial
  begin
    #1000000;
    failures++;
    results;
  end
endmodule : lscm_alu_tb
`default_nettype wire
